// File: logic/acs_pkg.sv
// Constants shared by the converter control block and its clock divider.
// Assumes an 8-bit register port with a 3-bit address and a single 200 MHz clock.
package acs_pkg;
  // Register addresses on the plain register port
  localparam logic [2:0] ADDR_CTL = 3'h0;
  localparam logic [2:0] ADDR_SETUP = 3'h1;
  localparam logic [2:0] ADDR_PINSEL = 3'h2;
  localparam logic [2:0] ADDR_RES_HI = 3'h3;
  localparam logic [2:0] ADDR_RES_LO = 3'h4;
  // Field positions
  localparam int CTL_START_BIT = 7;
  localparam int CTL_PEND_BIT = 6;
  localparam int SETUP_ONE_BIT = 7;
  localparam int SETUP_PD_BIT = 6;
  localparam int SETUP_REF_BIT = 5;
  // Reset values
  localparam logic [7:0] SETUP_RST = 8'h80;
  localparam logic [7:0] PINSEL_RST = 8'h00;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic PEND_RST = 1'b1;
  // Variant masks for the smaller part
  localparam logic [7:0] PIN_MASK_SMALL = 8'h3F;
  localparam logic [3:0] CHAN_MASK_SMALL = 4'h7;
  // Conversion length in periods of the conversion clock
  localparam int CONV_TICKS = 16;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);
  localparam int CLK_MHZ = 200;
  // Conversion clock select codes
  localparam logic [2:0] CS_DIV2 = 3'h0;
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV1 = 3'h4;
  localparam logic [2:0] CS_DIV4 = 3'h5;
  localparam logic [2:0] CS_DIV16 = 3'h6;

  // Last count value of the divider for a select code; undefined codes run as /2
  function automatic logic [4:0] div_last(input logic [2:0] sel);
    case (sel)
      CS_DIV1: div_last = 5'h00;
      CS_DIV2: div_last = 5'h01;
      CS_DIV4: div_last = 5'h03;
      CS_DIV8: div_last = 5'h07;
      CS_DIV16: div_last = 5'h0F;
      CS_DIV32: div_last = 5'h1F;
      default: div_last = 5'h01;
    endcase
  endfunction : div_last
endpackage : acs_pkg

// File: logic/acs_div_if.sv
// Link between the control block and its conversion clock divider.
// Assumes both ends run on the same clock.
interface acs_div_if;
  logic restart;
  logic [2:0] sel;
  logic tick;
  modport ctl (output restart, output sel, input tick);
  modport div (input restart, input sel, output tick);
endinterface : acs_div_if

// File: logic/acs_clk_div.sv
// Conversion clock divider: one-cycle tick at the selected fraction of the system clock.
// Assumes restart and select come from flip-flops in the control block.
module acs_clk_div (
  input wire logic clk,
  input wire logic rst,
  acs_div_if.div dv
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } acs_div_state_t;

  acs_div_state_t s_r;
  acs_div_state_t s_nxt;

  // Count to the last value, then tick; >= keeps a lowered ratio from wrapping long
  always_comb begin
    s_nxt = s_r;
    if (dv.restart) begin
      s_nxt.cnt = 5'h00;
      s_nxt.tick = 1'b0;
    end else if (s_r.cnt >= acs_pkg::div_last(dv.sel)) begin
      s_nxt.cnt = 5'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
      s_nxt.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dv.tick = s_r.tick;

  chk_div_half_rate: assert property (@(posedge clk) disable iff (rst)
    (dv.tick && !dv.restart && dv.sel == 3'h0) ##1 (!dv.restart && dv.sel == 3'h0) |-> !dv.tick ##1 dv.tick)
    else $error("divide-by-two tick spacing wrong");
  chk_div_full_rate: assert property (@(posedge clk) disable iff (rst)
    (dv.tick && !dv.restart && dv.sel == 3'h4) ##1 (!dv.restart && dv.sel == 3'h4) |-> dv.tick ##1 dv.tick)
    else $error("undivided tick not every cycle");
  chk_div_restart: assert property (@(posedge clk) disable iff (rst)
    dv.restart |=> !dv.tick)
    else $error("tick right after restart");
endmodule : acs_clk_div

// File: logic/acs_adc_ctl.sv
// Control and sequencing logic around a 12-bit successive-approximation converter.
// Assumes the converter macro presents its result on conv_result when told the run is over,
// and that the port pin muxes and interrupt controller sit outside and obey the outputs here.
// Summary of operation
// - Power-down bit 0 keeps converter powered; 1 switches it off.
// - Setup register top bit reads 1, bits 4 and 3 read 0.
// - Reference select 0 uses supply, 1 uses external pin or regulator.
// - Reference select 1 gives shared pin its reference function, disables others.
// - Clock select codes pick f/2, /8, /32, undivided, /4, /16.
// - Pin-select bits 0..3 make port B pins 3..6 analog inputs 0..3.
// - Bits 4,5 map port C pins 0,1; large part bits 6,7 port D.
// - Small part bits 7,6 read 0; implemented pin bits reset to 0.
// - Start bit low-high-low begins one conversion on a powered converter.
// - Start held high holds a powered converter in reset, pending flag forced 1; here the flag is set only when start rises while powered, not after power-up.
// - Pending flag read-only, 1 while running, cleared when conversion finishes.
// - Each conversion end raises the converter interrupt request.
// - One conversion lasts sixteen conversion clock periods.
// - Result left-aligned: high byte bits 11..4, low byte top nibble, rest 0.
// - Channel field routes exactly one input to the converter; on the large part codes 10 to 15 route none.
// - Analog pins lose pull-high and have port direction overridden.
module acs_adc_ctl #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [11:0] conv_result,
  output logic conv_power_on,
  output logic conv_reset,
  output logic conv_clk_en,
  output logic [9:0] conv_channel,
  output logic ref_from_pin,
  output logic ref_pin_func,
  output logic [7:0] analog_pin_en,
  output logic [7:0] pullhigh_off,
  output logic [7:0] dir_override,
  output logic conv_done_irq
);
  // Register map on the plain port, one byte each:
  //   0 conversion control: start, pending flag (read only), two zeros, channel code
  //   1 converter setup: fixed one, power-down, reference select, two zeros, clock code
  //   2 analog pin select; the smaller part keeps only the low six bits
  //   3 and 4 result bytes, left aligned, read only
  //   5 to 7 read as zero and ignore writes
  // Reads answer one cycle after the strobe and show zero otherwise, so idle data never
  // leaks a stale register onto a shared read bus.
  typedef struct packed {
    logic start;
    logic pend;
    logic pwr_on;
    logic [3:0] chan;
    logic pd;
    logic vref;
    logic [2:0] clk_sel;
    logic [7:0] pin_en;
    logic [11:0] result;
    logic busy;
    logic [3:0] tick_cnt;
    logic restart;
    logic clk_en;
    logic done;
    logic conv_rst;
    logic [9:0] route;
    logic [7:0] rdata;
  } acs_ctl_state_t;

  localparam logic [7:0] PIN_MASK = LARGE_VARIANT ? 8'hFF : acs_pkg::PIN_MASK_SMALL;
  localparam logic [3:0] CHAN_MASK = LARGE_VARIANT ? 4'hF : acs_pkg::CHAN_MASK_SMALL;

  acs_ctl_state_t s_r;
  acs_ctl_state_t s_nxt;
  acs_div_if div_bus ();

  // Channel code to one-hot input select; bit n is analog input n, unused codes select nothing
  function automatic logic [9:0] chan_route(input logic [3:0] ch);
    logic [9:0] r;
    r = 10'h000;
    if (LARGE_VARIANT) begin
      case (ch)
        4'h6: r = 10'h100;
        4'h7: r = 10'h200;
        4'h8: r = 10'h040;
        4'h9: r = 10'h080;
        default: r = (ch < 4'h6) ? 10'(10'h001 << ch) : 10'h000;
      endcase
    end else begin
      r = 10'(10'h001 << ch[2:0]);
    end
    return r;
  endfunction : chan_route

  acs_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .dv(div_bus.div)
  );

  // Divider steered from flip-flops so its restart never glitches
  assign div_bus.restart = s_r.restart;
  assign div_bus.sel = s_r.clk_sel;

  // Next-state logic: conversion progress first, then register writes override it
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.done = 1'b0;
    s_nxt.clk_en = 1'b0;
    s_nxt.restart = 1'b0;
    // Stale divider ticks in the restart cycle are not counted
    if (s_r.busy && !s_r.restart && div_bus.tick && !s_r.pd) begin
      s_nxt.clk_en = 1'b1;
      if (s_r.tick_cnt == acs_pkg::CONV_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.pend = 1'b0;
        s_nxt.result = conv_result;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.tick_cnt = s_r.tick_cnt + 4'h1;
      end
    end
    // Powering down abandons a run but leaves the flag and result alone
    if (s_r.pd) begin
      s_nxt.busy = 1'b0;
    end
    if (wr_en) begin
      case (addr)
        acs_pkg::ADDR_CTL: begin
          s_nxt.chan = wdata[3:0] & CHAN_MASK;
          s_nxt.start = wdata[acs_pkg::CTL_START_BIT];
          if (!s_r.pd) begin
            if (wdata[acs_pkg::CTL_START_BIT] && !s_r.start) begin
              s_nxt.pend = 1'b1;
              s_nxt.busy = 1'b0;
              s_nxt.done = 1'b0;
              s_nxt.result = s_r.result; // Aborted run keeps the old result
            end else if (!wdata[acs_pkg::CTL_START_BIT] && s_r.start) begin
              s_nxt.busy = 1'b1;
              s_nxt.pend = 1'b1;
              s_nxt.tick_cnt = 4'h0;
              s_nxt.restart = 1'b1;
            end
          end
        end
        acs_pkg::ADDR_SETUP: begin
          s_nxt.pd = wdata[acs_pkg::SETUP_PD_BIT];
          s_nxt.vref = wdata[acs_pkg::SETUP_REF_BIT];
          s_nxt.clk_sel = wdata[2:0];
        end
        acs_pkg::ADDR_PINSEL: begin
          s_nxt.pin_en = wdata & PIN_MASK;
        end
        default: begin
        end
      endcase
    end
    // Converter held in reset while start stays high on a powered converter
    s_nxt.conv_rst = s_nxt.start && !s_nxt.pd;
    s_nxt.route = chan_route(s_nxt.chan);
    s_nxt.pwr_on = !s_nxt.pd;
    if (rd_en) begin
      case (addr)
        acs_pkg::ADDR_CTL: s_nxt.rdata = {s_r.start, s_r.pend, 2'b00, s_r.chan};
        acs_pkg::ADDR_SETUP: s_nxt.rdata = {1'b1, s_r.pd, s_r.vref, 2'b00, s_r.clk_sel};
        acs_pkg::ADDR_PINSEL: s_nxt.rdata = s_r.pin_en;
        acs_pkg::ADDR_RES_HI: s_nxt.rdata = s_r.result[11:4];
        acs_pkg::ADDR_RES_LO: s_nxt.rdata = {s_r.result[3:0], 4'h0};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register with documented power-on values
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.pend <= acs_pkg::PEND_RST;
      s_r.chan <= acs_pkg::CHAN_RST;
      s_r.pd <= acs_pkg::SETUP_RST[acs_pkg::SETUP_PD_BIT];
      s_r.vref <= acs_pkg::SETUP_RST[acs_pkg::SETUP_REF_BIT];
      s_r.clk_sel <= acs_pkg::SETUP_RST[2:0];
      s_r.pin_en <= acs_pkg::PINSEL_RST;
      s_r.route <= 10'h001;
      s_r.pwr_on <= !acs_pkg::SETUP_RST[acs_pkg::SETUP_PD_BIT];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs taken straight from the state flip-flops
  assign rdata = s_r.rdata;
  assign conv_power_on = s_r.pwr_on;
  assign conv_reset = s_r.conv_rst;
  assign conv_clk_en = s_r.clk_en;
  assign conv_channel = s_r.route;
  assign ref_from_pin = s_r.vref;
  assign ref_pin_func = s_r.vref;
  assign analog_pin_en = s_r.pin_en;
  assign pullhigh_off = s_r.pin_en;
  assign dir_override = s_r.pin_en;
  assign conv_done_irq = s_r.done;

  // Helper: conversion clock periods seen since the last run began
  logic [4:0] seen_ticks_r;
  always_ff @(posedge clk) begin
    if (rst || s_r.restart) begin
      seen_ticks_r <= 5'h00;
    end else if (s_r.clk_en) begin
      seen_ticks_r <= seen_ticks_r + 5'h01;
    end
  end

  chk_power_follows: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == 3'h1) |=> conv_power_on == !$past(wdata[6]))
    else $error("power output does not follow power-down bit");
  chk_setup_fixed_bits: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == 3'h1) |=> rdata[7] && rdata[4:3] == 2'b00)
    else $error("setup fixed bits read wrong");
  chk_ref_select: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == 3'h1) |=> ref_from_pin == $past(wdata[5]) && ref_pin_func == ref_from_pin)
    else $error("reference select not applied");
  chk_pin_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == 3'h2) |=> analog_pin_en == ($past(wdata) & PIN_MASK))
    else $error("pin select not stored as masked");
  chk_pin_override: assert property (@(posedge clk) disable iff (rst)
    pullhigh_off == analog_pin_en && dir_override == analog_pin_en)
    else $error("analog pin keeps pull-high or direction");
  chk_start_reset: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == 3'h0 && wdata[7] && !s_r.start && !s_r.pd) |=> conv_reset && s_r.pend && !s_r.busy)
    else $error("rising start did not reset converter");
  chk_start_runs: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == 3'h0 && !wdata[7] && s_r.start && !s_r.pd) |=> s_r.busy && s_r.restart ##1 !conv_reset)
    else $error("falling start did not begin conversion");
  chk_conv_length: assert property (@(posedge clk) disable iff (rst)
    conv_done_irq |-> seen_ticks_r == 5'h0F && conv_clk_en)
    else $error("conversion not sixteen periods");
  chk_done_clears: assert property (@(posedge clk) disable iff (rst)
    $rose(conv_done_irq) |-> !s_r.pend && $past(s_r.pend) && $past(s_r.busy) ##1 !conv_done_irq)
    else $error("pending flag or request wrong at end");
  chk_pd_ignores: assert property (@(posedge clk) disable iff (rst)
    (s_r.pd && wr_en && addr == 3'h0) |=> $stable(s_r.pend) && $stable(s_r.result) && !s_r.busy)
    else $error("start acted while powered down");
  chk_result_align: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == 3'h4) |=> rdata[3:0] == 4'h0 && rdata[7:4] == $past(s_r.result[3:0]))
    else $error("low result byte misaligned");
  chk_chan_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot0(conv_channel) && (s_r.chan >= 4'hA || $onehot(conv_channel)))
    else $error("channel route not one-hot");

  // Guards on run sequencing and the read path
  // Completion request lasts exactly one cycle
  chk_irq_single: assert property (@(posedge clk) disable iff (rst)
    conv_done_irq |=> !conv_done_irq)
    else $error("completion request longer than one cycle");
  // No conversion clock pulses reach the macro outside a run
  chk_clk_en_idle: assert property (@(posedge clk) disable iff (rst)
    !s_r.busy |=> !conv_clk_en)
    else $error("conversion clock pulse while idle");
  // Pending flag moves only through a run or a control write
  chk_pend_steady: assert property (@(posedge clk) disable iff (rst)
    (!s_r.busy && !(wr_en && addr == acs_pkg::ADDR_CTL)) |=> $stable(s_r.pend))
    else $error("pending flag changed with no cause");
  // Result registers change only together with the completion request
  chk_result_steady: assert property (@(posedge clk) disable iff (rst)
    !conv_done_irq |-> $stable(s_r.result))
    else $error("result changed outside completion");
  // Smaller part never shows its two missing pin bits
  chk_pin_trim: assert property (@(posedge clk) disable iff (rst)
    LARGE_VARIANT || analog_pin_en[7:6] == 2'h0)
    else $error("missing pin bits set on smaller part");
  // A powered-down converter never runs
  chk_run_powered: assert property (@(posedge clk) disable iff (rst)
    s_r.pd |=> !s_r.busy)
    else $error("run continued while powered down");
  // Divider restart always opens a fresh count
  chk_restart_clean: assert property (@(posedge clk) disable iff (rst)
    s_r.restart |-> s_r.busy && s_r.tick_cnt == 4'h0)
    else $error("restart without a fresh run");
  // Converter held in reset is never mid-run
  chk_reset_idle: assert property (@(posedge clk) disable iff (rst)
    conv_reset |-> !s_r.busy)
    else $error("converter reset during a run");
  // Control read shows the pending flag and zero unused bits
  chk_ctl_read: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == acs_pkg::ADDR_CTL) |=> rdata[6] == $past(s_r.pend) && rdata[5:4] == 2'h0)
    else $error("control read wrong");
  // Clock code reaches the divider one cycle after the write
  chk_clk_sel_write: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == acs_pkg::ADDR_SETUP) |=> div_bus.sel == $past(wdata[2:0]))
    else $error("clock code not passed to divider");
  // High result byte carries bits 11 to 4
  chk_result_high: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == acs_pkg::ADDR_RES_HI) |=> rdata == $past(s_r.result[11:4]))
    else $error("high result byte misaligned");
endmodule : acs_adc_ctl

// File: testbench/acs_conv_model.sv
// Behavioural converter macro standing on the far side of the control block.
// Assumes the bench supplies the sample value and that the macro shares the system clock.
module acs_conv_model (
  input wire logic clk,
  input wire logic conv_power_on,
  input wire logic conv_reset,
  input wire logic conv_clk_en,
  input wire logic [11:0] sample,
  output logic [11:0] conv_result,
  output logic [4:0] tick_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // Unpowered or held in reset the output means nothing, so show the inverse, not a stale value
  assign conv_result = (conv_power_on && !conv_reset) ? sample : ~sample;

  // Conversion clock periods seen since the last reset pulse
  always @(posedge clk) begin
    if (conv_reset) begin
      tick_count <= 5'h00;
    end else if (conv_clk_en) begin
      tick_count <= tick_count + 5'h01;
    end
  end
endmodule : acs_conv_model

// File: testbench/acs_adc_ctl_tb.sv
// Self-checking bench for the converter control block, both part variants on one register port.
// Assumes the design files and the converter model are compiled first.
module acs_adc_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr_en, rd_en, power_on, conv_rst, clk_en, ref_pin, ref_func, irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rdata_s, pin_en, pull_off, dir_ovr;
  logic [11:0] conv_result, sample;
  logic [9:0] chan;
  logic [4:0] ticks;
  int bad_count, n_tests;

  acs_adc_ctl #(.LARGE_VARIANT(1'b1)) i_acs_adc_ctl (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_result(conv_result), .conv_power_on(power_on),
    .conv_reset(conv_rst), .conv_clk_en(clk_en), .conv_channel(chan), .ref_from_pin(ref_pin),
    .ref_pin_func(ref_func), .analog_pin_en(pin_en), .pullhigh_off(pull_off), .dir_override(dir_ovr),
    .conv_done_irq(irq));
  // Smaller part rides on the same bus so its trimmed pin register can be read back
  acs_adc_ctl #(.LARGE_VARIANT(1'b0)) i_acs_adc_ctl_small (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_s), .conv_result(conv_result),
    .conv_power_on(), .conv_reset(), .conv_clk_en(), .conv_channel(), .ref_from_pin(),
    .ref_pin_func(), .analog_pin_en(), .pullhigh_off(), .dir_override(), .conv_done_irq());
  acs_conv_model i_acs_conv_model (.clk(clk), .conv_power_on(power_on), .conv_reset(conv_rst),
    .conv_clk_en(clk_en), .sample(sample), .conv_result(conv_result), .tick_count(ticks));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // Bus cycles; the trailing delay lets the write's effects land before anyone looks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] ds);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    ds = rdata_s;
  endtask : rd

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d, ds;
    rd(a, d, ds);
    chk(d, exp);
  endtask : rdchk

  // Bounded wait for the one-cycle completion pulse
  task automatic wait_irq(input int lim, output int cyc);
    cyc = 0;
    while (irq !== 1'b1 && cyc < lim) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask : wait_irq

  task automatic t_reset();
    rdchk(acs_pkg::ADDR_SETUP, 8'h80);
    rdchk(acs_pkg::ADDR_PINSEL, 8'h00);
    rdchk(acs_pkg::ADDR_CTL, 8'h40);
    rdchk(3'h5, 8'h00);
    chk({power_on, chan}, 12'h401);
  endtask : t_reset

  task automatic t_setup();
    wr(acs_pkg::ADDR_SETUP, 8'hFF);
    rdchk(acs_pkg::ADDR_SETUP, 8'hE7);
    chk({power_on, ref_pin, ref_func}, 12'h003);
    wr(acs_pkg::ADDR_SETUP, 8'h00);
    rdchk(acs_pkg::ADDR_SETUP, 8'h80);
    chk({power_on, ref_pin, ref_func}, 12'h004);
  endtask : t_setup

  task automatic t_pins();
    logic [7:0] d, ds;
    for (int i = 0; i < 8; i++) begin
      wr(acs_pkg::ADDR_PINSEL, 8'h01 << i);
      chk(pin_en, 8'h01 << i);
      chk(pull_off, 8'h01 << i);
      chk(dir_ovr, 8'h01 << i);
      rdchk(acs_pkg::ADDR_PINSEL, 8'h01 << i);
    end
    wr(acs_pkg::ADDR_PINSEL, 8'hFF);
    rd(acs_pkg::ADDR_PINSEL, d, ds);
    chk(ds, 8'h3F);
    wr(acs_pkg::ADDR_PINSEL, 8'h00);
  endtask : t_pins

  // Codes 6 and 7 pick the amplifier inputs 8 and 9, codes 8 and 9 the port D pins
  task automatic t_chan();
    int map[10] = '{0, 1, 2, 3, 4, 5, 8, 9, 6, 7};
    for (int c = 0; c < 16; c++) begin
      wr(acs_pkg::ADDR_CTL, 8'(c));
      chk(chan, (c < 10) ? (10'h001 << map[c]) : 10'h000);
    end
    wr(acs_pkg::ADDR_CTL, 8'h00);
  endtask : t_chan

  // One full conversion per defined clock code, plus undefined code 3 running as /2
  // At 200 MHz even /32 is shorter than the slowest period software must pick; accuracy not modelled
  task automatic t_conv();
    logic [2:0] code[7] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h3};
    int div[7] = '{1, 2, 4, 8, 16, 32, 2};
    int cyc;
    for (int k = 0; k < 7; k++) begin
      sample = sample + 12'h3A7;
      wr(acs_pkg::ADDR_SETUP, {5'h10, code[k]});
      repeat (8) @(posedge clk);
      wr(acs_pkg::ADDR_CTL, 8'h80);
      chk(conv_rst, 1'b1);
      rdchk(acs_pkg::ADDR_CTL, 8'hC0);
      wr(acs_pkg::ADDR_CTL, 8'h00);
      wait_irq(700, cyc);
      chk(cyc >= 16 * div[k] && cyc <= 16 * div[k] + 4, 1'b1);
      rdchk(acs_pkg::ADDR_CTL, 8'h00);
      chk(ticks, 5'h10);
      rdchk(acs_pkg::ADDR_RES_HI, sample[11:4]);
      rdchk(acs_pkg::ADDR_RES_LO, {sample[3:0], 4'h0});
    end
  endtask : t_conv

  // Restart in mid-run, then a start pulse while powered down
  task automatic t_abort_pd();
    int cyc;
    wr(acs_pkg::ADDR_SETUP, 8'h82);
    wr(acs_pkg::ADDR_CTL, 8'h80);
    wr(acs_pkg::ADDR_CTL, 8'h00);
    rdchk(acs_pkg::ADDR_CTL, 8'h40);
    wr(acs_pkg::ADDR_CTL, 8'h80);
    chk(conv_rst, 1'b1);
    wr(acs_pkg::ADDR_CTL, 8'h00);
    wait_irq(700, cyc);
    chk(cyc >= 512 && cyc <= 516, 1'b1);
    wr(acs_pkg::ADDR_SETUP, 8'hC0);
    sample = ~sample;
    wr(acs_pkg::ADDR_CTL, 8'h80);
    chk(conv_rst, 1'b0);
    wr(acs_pkg::ADDR_CTL, 8'h00);
    wait_irq(100, cyc);
    chk(12'(cyc), 12'h064);
    rdchk(acs_pkg::ADDR_CTL, 8'h00);
    rdchk(acs_pkg::ADDR_RES_HI, ~sample[11:4]);
  endtask : t_abort_pd

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Watchdog set well beyond the roughly 10 us the scenarios need
  initial begin
    #100us;
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    sample = 12'hA5C;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_pins();
    t_chan();
    t_conv();
    t_abort_pd();
    conclude();
  end
endmodule : acs_adc_ctl_tb
